// File: common/conv_cfg_pkg.sv
// Package with offsets, field layout and reset values of the converter configuration register.
package conv_cfg_pkg;

  // Register index as printed; byte address is four times the index.
  localparam logic [15:0] CFG_REG_INDEX   = 16'h7813;
  localparam logic [17:0] CFG_REG_ADDR    = {CFG_REG_INDEX, 2'b00};
  // Load-source register, a word after the configuration register.
  localparam logic [17:0] LOAD_REG_ADDR   = 18'h1_E050;

  // Field positions.
  localparam int          PHASE_LSB       = 12;
  localparam int          CAP_LSB         = 4;
  localparam int          RATE_LSB        = 0;

  // Mask of the bits the host may always write.
  localparam logic [15:0] HOST_WRITE_MASK = 16'hF000;
  // Mask of the bits that only a configuration load may write.
  localparam logic [15:0] LOAD_WRITE_MASK = 16'h0FFF;
  // Value after reset: only the second converter's phase bit is set.
  localparam logic [15:0] CFG_RESET       = 16'h2000;

  // Switching-rate codes.
  localparam logic [1:0]  RATE_2MHZ       = 2'h1;
  localparam logic [1:0]  RATE_4MHZ       = 2'h2;

  // Load source codes.
  typedef enum logic [1:0] {
    SRC_NONE,
    SRC_OTP,
    SRC_EXT_MEM
  } load_src_t;

  // Decoded converter settings handed to the power stages.
  typedef struct packed {
    logic [3:0] clock_invert;
    logic [7:0] output_cap_range;
    logic [1:0] rate_is_4mhz;
    logic [1:0] rate_valid;
  } conv_ctrl_t;

endpackage

// File: hdl/conv_cfg_reg.sv
// Converter phase, output capacitor and switching rate configuration register on APB.
`timescale 1ns/100ps
// Behaviour
// - Bits 15..12 invert switching clock phase of converters four..one; 1 means inverted.
// - Reset value has bit 13 set and all other fields zero.
// - Rate fields at 3:2 and 1:0; code 01 is 2.0 MHz, 00 and 11 reserved.
// - Rate code 10 selects 4.0 MHz for its converter.
// - Capacitor and rate fields change only through a configuration load from OTP or memory.
// - Host writes leave protected fields unchanged; they read back their stored value.
module conv_cfg_reg (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [31:0]               paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic                      load_strobe,
  input  wire logic [15:0]               load_data,
  input  wire conv_cfg_pkg::load_src_t   load_source,
  output conv_cfg_pkg::conv_ctrl_t       conv_ctrl
);

  // Bus timing of this slave, for whoever drives it.
  // A transfer is taken at the rising edge that sees psel high and penable low.
  // That edge is the setup edge, and every answer is computed from it alone.
  // The answer stands in the following cycle, which is the access cycle.
  // In that cycle pready is high, with prdata and pslverr valid beside it.
  // No wait state is ever inserted, so a master sees pready at its first access edge.
  // The answer lasts exactly one cycle and then pready falls again.
  // Read data and the error flag hold their last value until the next setup edge.
  // A write to the configuration word takes effect at the setup edge.
  // The new value is therefore readable from the access cycle onwards.
  // Back to back transfers are allowed, with or without an idle cycle between them.
  // Each transfer carries one aligned 32-bit word; only bits 15:0 mean anything.
  // The upper half of every read word is zero.
  //
  // Address map.
  // The configuration word sits at its byte address, four times its index.
  // The load-source word sits one word above it and is read-only.
  // Any other address answers with pslverr high, reads zero and ignores writes.
  // The upper address bits must be zero for either word to be hit.
  //
  // Field protection.
  // The host may only ever change the four clock phase bits.
  // The capacitor range and switching rate fields ignore host writes silently.
  // They still read back whatever value they currently hold.
  // Silent ignoring was chosen so that boot code writing a whole image cannot fault.
  // A user who needs to change those fields must go through a configuration load.
  //
  // Configuration load.
  // A load is a one-cycle strobe on the same clock, with a full 16-bit image.
  // It only acts when its source is the one-time memory or the external memory.
  // A strobe marked with no source is dropped, so a stray pulse cannot alter the fields.
  // An accepted load writes every field, the phase bits included.
  // When a host write to the word falls in the same cycle as a load, the host wins.
  // In that case the phase bits come from the host and the other fields from the load.
  // This keeps software in charge of the phase bits whenever its write meets a load; a load alone still replaces them.
  // The source of the last accepted load is kept for software to read back.
  //
  // Converter outputs.
  // The decoded controls are registered and change in the same cycle as the word.
  // Phase bits pass through unchanged, bit 3 belonging to the fourth converter.
  // The capacitor range codes pass through as stored, without interpretation.
  // Each of the first two converters gets a 4 MHz flag and a rate-valid flag.
  // A reserved rate code leaves the valid flag low, so the stage may hold off.
  // The 4 MHz flag is never high while the valid flag is low.
  //
  // Reset.
  // The reset is asynchronous and active low, and it acts on the whole state.
  // After reset only the second converter's phase bit is set.
  // Both rate fields then hold a reserved code, so both valid flags start low.
  // A loader is expected to bring in real rate codes before the converters start.
  // The first transfer may begin at the first edge after reset is released.
  //
  // Hazards.
  // The load strobe and its data must come from logic on this same clock.
  // Nothing here resynchronises them, so an unsynchronised loader would corrupt fields.
  // The error flag is a plain response; it does not latch and needs no clearing.
  //
  // All state of the block.
  typedef struct packed {
    logic [15:0]              cfg;
    logic [31:0]              rdata;
    logic                     ready;
    logic                     slverr;
    conv_cfg_pkg::conv_ctrl_t ctrl;
    conv_cfg_pkg::load_src_t  last_src;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  logic        setup;
  logic        hit_cfg;
  logic        hit_load;
  logic        load_ok;
  logic [15:0] cfg_v;

  // Request decode; every transfer answers in its first access cycle.
  assign setup    = psel && !penable;
  assign hit_cfg  = paddr[17:0] == conv_cfg_pkg::CFG_REG_ADDR && paddr[31:18] == 14'h0000;
  assign hit_load = paddr[17:0] == conv_cfg_pkg::LOAD_REG_ADDR && paddr[31:18] == 14'h0000;
  // Only an OTP or external memory load may touch protected fields.
  assign load_ok  = load_strobe && (load_source == conv_cfg_pkg::SRC_OTP ||
                                    load_source == conv_cfg_pkg::SRC_EXT_MEM);

  // Next-state logic for the register, bus answer and decoded outputs.
  always_comb begin
    st_nxt       = st_r;
    cfg_v        = st_r.cfg;
    st_nxt.ready = 1'b0;
    if (load_ok) begin
      // Load path writes every field, phase bits included.
      cfg_v             = load_data;
      st_nxt.last_src   = load_source;
    end
    if (setup) begin
      st_nxt.ready  = 1'b1;
      st_nxt.slverr = !(hit_cfg || hit_load);
      st_nxt.rdata  = 32'h0000_0000;
      if (pwrite && hit_cfg) begin
        // Host path touches the phase bits only; protected bits keep their value.
        cfg_v = (cfg_v & conv_cfg_pkg::LOAD_WRITE_MASK) |
                (pwdata[15:0] & conv_cfg_pkg::HOST_WRITE_MASK);
      end else if (!pwrite && hit_cfg) begin
        st_nxt.rdata = {16'h0000, st_r.cfg};
      end else if (!pwrite && hit_load) begin
        st_nxt.rdata = {30'h0000_0000, st_r.last_src};
      end
    end
    st_nxt.cfg                   = cfg_v;
    // Decoded controls for the converters.
    st_nxt.ctrl.clock_invert     = cfg_v[conv_cfg_pkg::PHASE_LSB +: 4];
    st_nxt.ctrl.output_cap_range = cfg_v[conv_cfg_pkg::CAP_LSB +: 8];
    for (int i = 0; i < 2; i++) begin
      st_nxt.ctrl.rate_is_4mhz[i] = cfg_v[2*i +: 2] == conv_cfg_pkg::RATE_4MHZ;
      st_nxt.ctrl.rate_valid[i]   = cfg_v[2*i +: 2] == conv_cfg_pkg::RATE_2MHZ ||
                                    cfg_v[2*i +: 2] == conv_cfg_pkg::RATE_4MHZ;
    end
  end

  // State register with its reset values.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r                       <= '0;
      st_r.cfg                   <= conv_cfg_pkg::CFG_RESET;
      st_r.ctrl.clock_invert     <= conv_cfg_pkg::CFG_RESET[15:12];
    end else begin
      st_r <= st_nxt;
    end
  end

  assign prdata    = st_r.rdata;
  assign pready    = st_r.ready;
  assign pslverr   = st_r.slverr;
  assign conv_ctrl = st_r.ctrl;

  // Checks kept next to the logic.
  a_host_protect: assert property (@(posedge pclk) disable iff (!presetn)
    !load_ok |=> st_r.cfg[11:0] == $past(st_r.cfg[11:0]))
    else $error("Protected field changed without a configuration load.");

  a_load_write: assert property (@(posedge pclk) disable iff (!presetn)
    load_ok |=> st_r.cfg[11:0] == $past(load_data[11:0]))
    else $error("Configuration load did not update protected fields.");

  a_host_phase: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && pwrite && hit_cfg && !load_ok) |=> st_r.cfg[15:12] == $past(pwdata[15:12]))
    else $error("Host write did not set phase bits.");

  a_phase_out: assert property (@(posedge pclk) disable iff (!presetn)
    conv_ctrl.clock_invert == st_r.cfg[15:12])
    else $error("Phase outputs disagree with register.");

  a_rate_4m: assert property (@(posedge pclk) disable iff (!presetn)
    conv_ctrl.rate_is_4mhz[1] == (st_r.cfg[3:2] == 2'b10))
    else $error("Second converter rate decode wrong.");

  a_rate_valid: assert property (@(posedge pclk) disable iff (!presetn)
    conv_ctrl.rate_valid[0] == (st_r.cfg[1:0] == 2'b01 || st_r.cfg[1:0] == 2'b10))
    else $error("First converter rate validity wrong.");

  a_read_back: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && hit_cfg) |=> pready && prdata == {16'h0000, $past(st_r.cfg)})
    else $error("Read data does not match stored register.");

  a_reset_value: assert property (@(posedge pclk)
    $rose(presetn) |-> st_r.cfg == 16'h2000 || $past(load_strobe))
    else $error("Register reset value wrong.");

  // The phase outputs start at their reset value.
  a_reset_phase: assert property (@(posedge pclk)
    $rose(presetn) |-> conv_ctrl.clock_invert == 4'b0010 || $past(load_strobe))
    else $error("Phase outputs wrong after reset.");

  // The answer is a single-cycle pulse.
  a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("Ready stood for more than one cycle.");

  // Every setup edge is answered in the next cycle.
  a_ready_answer: assert property (@(posedge pclk) disable iff (!presetn)
    setup |=> pready)
    else $error("Transfer was not answered in its access cycle.");

  // Ready never rises without a setup edge before it.
  a_ready_cause: assert property (@(posedge pclk) disable iff (!presetn)
    pready |-> $past(setup))
    else $error("Ready rose without a transfer.");

  // Unmapped addresses answer with an error.
  a_err_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && !hit_cfg && !hit_load) |=> pslverr)
    else $error("Unmapped address was not refused.");

  // Mapped addresses answer without an error.
  a_err_mapped: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && (hit_cfg || hit_load)) |=> !pslverr)
    else $error("Mapped address was refused.");

  // Unmapped reads return zero.
  a_err_read_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && !hit_cfg && !hit_load) |=> prdata == 32'h0000_0000)
    else $error("Unmapped read returned data.");

  // Writes elsewhere leave the word alone.
  a_unmapped_keep: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && pwrite && !hit_cfg && !load_ok) |=> st_r.cfg == $past(st_r.cfg))
    else $error("Write to another address changed the register.");

  // Phase bits hold without a host write or a load.
  a_phase_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (!load_ok && !(setup && pwrite && hit_cfg)) |=> st_r.cfg[15:12] == $past(st_r.cfg[15:12]))
    else $error("Phase bits changed on their own.");

  // A load alone also writes the phase bits.
  a_load_phase: assert property (@(posedge pclk) disable iff (!presetn)
    (load_ok && !(setup && pwrite && hit_cfg)) |=> st_r.cfg[15:12] == $past(load_data[15:12]))
    else $error("Load did not write the phase bits.");

  // A host write beats a load in the same cycle for the phase bits.
  a_host_wins: assert property (@(posedge pclk) disable iff (!presetn)
    (load_ok && setup && pwrite && hit_cfg) |=> st_r.cfg[15:12] == $past(pwdata[15:12]))
    else $error("Host phase write lost against a load.");

  // A strobe with no source changes nothing.
  a_none_source: assert property (@(posedge pclk) disable iff (!presetn)
    (load_strobe && load_source == conv_cfg_pkg::SRC_NONE && !(setup && pwrite && hit_cfg))
    |=> st_r.cfg == $past(st_r.cfg))
    else $error("Load without a source changed the register.");

  // Capacitor range outputs follow the stored fields.
  a_cap_out: assert property (@(posedge pclk) disable iff (!presetn)
    conv_ctrl.output_cap_range == st_r.cfg[11:4])
    else $error("Capacitor range outputs disagree with register.");

  // First converter 4 MHz decode.
  a_rate_4m_first: assert property (@(posedge pclk) disable iff (!presetn)
    conv_ctrl.rate_is_4mhz[0] == (st_r.cfg[1:0] == 2'b10))
    else $error("First converter rate decode wrong.");

  // Second converter validity decode.
  a_rate_valid_two: assert property (@(posedge pclk) disable iff (!presetn)
    conv_ctrl.rate_valid[1] == (st_r.cfg[3:2] == 2'b01 || st_r.cfg[3:2] == 2'b10))
    else $error("Second converter rate validity wrong.");

  // A 4 MHz flag never stands on a reserved code.
  a_rate_exclusive: assert property (@(posedge pclk) disable iff (!presetn)
    (conv_ctrl.rate_is_4mhz & ~conv_ctrl.rate_valid) == 2'b00)
    else $error("Rate flag set on a reserved code.");

  // The load-source word reads back the last accepted source.
  a_src_read: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && hit_load) |=> prdata == {30'h0000_0000, $past(st_r.last_src)})
    else $error("Load source read back wrong.");

  // An accepted load records its source.
  a_src_track: assert property (@(posedge pclk) disable iff (!presetn)
    load_ok |=> st_r.last_src == $past(load_source))
    else $error("Load source not recorded.");

  // The upper half of read data is always zero.
  a_rdata_upper: assert property (@(posedge pclk) disable iff (!presetn)
    pready |-> prdata[31:16] == 16'h0000)
    else $error("Upper read data not zero.");

  // Read data and error hold between transfers.
  a_rdata_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !setup |=> prdata == $past(prdata) && pslverr == $past(pslverr))
    else $error("Answer changed without a transfer.");

endmodule // conv_cfg_reg

// File: tb/conv_cfg_reg_tb.sv
// Self-checking bench for the converter configuration register.
`timescale 1ns/100ps
module conv_cfg_reg_tb;
  logic                     pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic                     load_strobe;
  logic [31:0]              paddr, pwdata, prdata, rd;
  logic [15:0]              load_data;
  conv_cfg_pkg::load_src_t  load_source;
  conv_cfg_pkg::conv_ctrl_t conv_ctrl;
  int                       err_count, checked;
  localparam logic [31:0]   CFG = 32'(conv_cfg_pkg::CFG_REG_ADDR);

  conv_cfg_reg dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .load_strobe(load_strobe), .load_data(load_data),
    .load_source(load_source), .conv_ctrl(conv_ctrl));

  // Free-running 40 ns clock.
  always #20 pclk = ~pclk;

  // Counts a comparison and reports a mismatch.
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    checked++;
    if (g !== x) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, x, g);
    end
  endtask

  // Prints the verdict and ends the run.
  task automatic print_verdict;
    if (err_count == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // One APB transfer; pready and the answer are taken at the same rising edge.
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 20) begin
      err_count++;
      print_verdict();
    end
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // One configuration load pulse, then a wait for the falling edge so the caller can check the decoded outputs.
  task automatic load(input conv_cfg_pkg::load_src_t s, input logic [15:0] d);
    @(posedge pclk);
    load_strobe <= 1'b1;
    load_source <= s;
    load_data <= d;
    @(posedge pclk);
    load_strobe <= 1'b0;
    @(negedge pclk);
  endtask

  // Reset values of register and outputs.
  task automatic t_reset;
    chk("rst_ctrl", 32'h0000_2000, {16'h0000, conv_ctrl});
    apb(1'b0, CFG, 32'h0000_0000);
    chk("rst_reg", 32'h0000_2000, rd);
  endtask

  // Host writes change only the phase bits.
  task automatic t_host;
    apb(1'b1, CFG, 32'h0000_5FFF);
    apb(1'b0, CFG, 32'h0000_0000);
    chk("host_reg", 32'h0000_5000, rd);
    chk("host_inv", 32'h0000_0005, {28'h0, conv_ctrl.clock_invert});
  endtask

  // Loads from both sources, and one with no source that must be ignored.
  task automatic t_load;
    load(conv_cfg_pkg::SRC_OTP, 16'hA396);
    chk("rate_otp", 32'h0000_0007, {28'h0, conv_ctrl[3:0]});
    apb(1'b0, CFG, 32'h0000_0000);
    chk("otp_reg", 32'h0000_A396, rd);
    load(conv_cfg_pkg::SRC_NONE, 16'hFFFF);
    apb(1'b0, CFG, 32'h0000_0000);
    chk("none_reg", 32'h0000_A396, rd);
    load(conv_cfg_pkg::SRC_EXT_MEM, 16'h0C3C);
    chk("rate_ext", 32'h0000_0C30, {16'h0, conv_ctrl[11:0]});
  endtask

  // Unmapped write is refused and leaves the register alone.
  task automatic t_unmapped;
    apb(1'b1, CFG + 32'h0000_0008, 32'h0000_FFFF);
    chk("slverr", 32'h0000_0001, {31'h0, e});
    apb(1'b0, CFG, 32'h0000_0000);
    chk("ext_reg", 32'h0000_0C3C, rd);
    apb(1'b0, 32'(conv_cfg_pkg::LOAD_REG_ADDR), 32'h0000_0000);
    chk("src_reg", 32'h0000_0002, rd);
  endtask

  // Main sequence.
  initial begin
    {pclk, presetn, psel, penable, pwrite, load_strobe} = '0;
    {paddr, pwdata, load_data, err_count, checked} = '0;
    load_source = conv_cfg_pkg::SRC_NONE;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    t_reset();
    t_host();
    t_load();
    t_unmapped();
    print_verdict();
  end
endmodule // conv_cfg_reg_tb
